// ### rtl/bcu_top.sv
// Purpose: branch and loop-control unit, driven over Avalon-MM
// Assumes: sequential pc is pc plus instruction length in words
// Notes:   a write to the command register executes one instruction
`timescale 1ns/1ps
`include "bcu_consts.svh"
module bcu_top (
    // system
    input  wire logic                  clk_sys,
    input  wire logic                  rst_b,
    // avalon-mm slave
    input  wire bcu_pkg::bcu_av_req_type av_req,
    output logic [31:0]                av_readdata,
    output logic                       av_waitrequest,
    // core status
    output bcu_pkg::bcu_flags_type     flags_out,
    output logic [31:0]                pc_out,
    output logic [31:0]                count_out,
    output logic                       taken_out
);
    import bcu_pkg::*;

    // command word: [3:0] op, [7:4] cond, [8] half select for XY codes,
    // [31:16] instruction word 2 / short displacement word
    logic [31:0]   cmd_r;
    logic [31:0]   opa_r;    // Rd / destination / count register
    logic [31:0]   opb_r;    // Rs / source / absolute target
    logic [31:0]   pc_r;
    bcu_flags_type flags_r;
    bcu_flags_type flags_y_r;
    logic          taken_r;
    logic [31:0]   rdata_r;
    logic          wait_r;
    bcu_state_type state_r;
    bcu_state_type state_nxt;

    bcu_op_type    op;
    logic [3:0]    cc;
    logic          use_y;
    logic [15:0]   word2;
    logic          cond_ok;
    bcu_flags_type fsel;
    logic [31:0]   pc_nxt;
    logic [31:0]   opa_nxt;
    logic          taken_nxt;
    bcu_flags_type flags_nxt;
    bcu_flags_type flags_y_nxt;
    logic [31:0]   dec;
    logic [32:0]   diff;
    logic [16:0]   dlo;
    logic [16:0]   dhi;

    assign op    = bcu_op_type'(cmd_r[3:0]);
    assign cc    = cmd_r[7:4];
    assign use_y = cmd_r[8];
    assign word2 = cmd_r[31:16];
    assign dec   = opa_r - 32'h00000001;
    assign diff  = {1'b0, opa_r} - {1'b0, opb_r};
    assign dlo   = {1'b0, opa_r[15:0]} - {1'b0, opb_r[15:0]};
    assign dhi   = {1'b0, opa_r[31:16]} - {1'b0, opb_r[31:16]};

    // condition evaluation
    function automatic logic cond_eval(input logic [3:0] c,
                                       input bcu_flags_type f);
        logic r;
        r = 1'b0;
        case (c)
            `BCU_CC_UC: r = 1'b1;
            `BCU_CC_LO: r = f.c;
            `BCU_CC_LS: r = f.c | f.z;
            `BCU_CC_HI: r = ~f.c & ~f.z;
            `BCU_CC_LT: r = f.n ^ f.v;
            `BCU_CC_GE: r = ~(f.n ^ f.v);
            `BCU_CC_LE: r = (f.n ^ f.v) | f.z;
            `BCU_CC_GT: r = ~(f.n ^ f.v) & ~f.z;
            `BCU_CC_C:  r = f.c;
            `BCU_CC_NC: r = ~f.c;
            `BCU_CC_EQ: r = f.z;
            `BCU_CC_NE: r = ~f.z;
            `BCU_CC_V:  r = f.v;
            `BCU_CC_NV: r = ~f.v;
            `BCU_CC_N:  r = f.n;
            `BCU_CC_NN: r = ~f.n;
            default:    r = 1'b0;
        endcase
        return r;
    endfunction : cond_eval

    assign fsel    = use_y ? flags_y_r : flags_r;
    assign cond_ok = cond_eval(cc, fsel);

    // execution datapath
    always_comb begin
        pc_nxt      = pc_r + 32'h00000001;
        opa_nxt     = opa_r;
        taken_nxt   = 1'b0;
        flags_nxt   = flags_r;
        flags_y_nxt = flags_y_r;
        case (op)
            BCU_OP_CDB: begin
                opa_nxt = dec;
                pc_nxt  = pc_r + 32'h00000002;
                if (dec != 32'h00000000) begin
                    pc_nxt    = pc_r + 32'h00000002
                              + {{16{word2[15]}}, word2};
                    taken_nxt = 1'b1;
                end
            end
            BCU_OP_CDBS: begin
                opa_nxt = dec;
                if (dec != 32'h00000000) begin
                    // 6-bit magnitude, bit 6 sign: +-63 words
                    pc_nxt    = cmd_r[22] ?
                        pc_r + 32'h00000001 - {26'h0, word2[5:0]} :
                        pc_r + 32'h00000001 + {26'h0, word2[5:0]};
                    taken_nxt = 1'b1;
                end
            end
            BCU_OP_CDSET, BCU_OP_CDCLR: begin
                pc_nxt = pc_r + 32'h00000002;
                if ((op == BCU_OP_CDSET) == flags_r.z) begin
                    opa_nxt = dec;
                    if (dec != 32'h00000000) begin
                        pc_nxt    = pc_r + 32'h00000002
                                  + {{16{word2[15]}}, word2};
                        taken_nxt = 1'b1;
                    end
                end
            end
            BCU_OP_JIND: begin
                pc_nxt    = opb_r;
                taken_nxt = 1'b1;
            end
            BCU_OP_RELS: begin
                if (cond_ok && word2[7:0] != 8'h00) begin
                    pc_nxt    = pc_r + 32'h00000001
                              + {{24{word2[7]}}, word2[7:0]};
                    taken_nxt = 1'b1;
                end
            end
            BCU_OP_RELL: begin
                pc_nxt = pc_r + 32'h00000002;
                if (cond_ok && word2 != 16'h0000) begin
                    pc_nxt    = pc_r + 32'h00000002
                              + {{16{word2[15]}}, word2};
                    taken_nxt = 1'b1;
                end
            end
            BCU_OP_ABS: begin
                pc_nxt = pc_r + 32'h00000003;
                if (cond_ok) begin
                    pc_nxt    = opb_r;
                    taken_nxt = 1'b1;
                end
            end
            BCU_OP_CMP: begin
                flags_nxt.n = diff[31];
                flags_nxt.c = diff[32];
                flags_nxt.z = (diff[31:0] == 32'h00000000);
                flags_nxt.v = (opa_r[31] ^ opb_r[31])
                            & (opa_r[31] ^ diff[31]);
            end
            BCU_OP_PAIRED_HALF_COMPARE: begin
                flags_nxt.n   = dlo[15];
                flags_nxt.c   = dlo[16];
                flags_nxt.z   = (dlo[15:0] == 16'h0000);
                flags_nxt.v   = (opa_r[15] ^ opb_r[15])
                              & (opa_r[15] ^ dlo[15]);
                flags_y_nxt.n = dhi[15];
                flags_y_nxt.c = dhi[16];
                flags_y_nxt.z = (dhi[15:0] == 16'h0000);
                flags_y_nxt.v = (opa_r[31] ^ opb_r[31])
                              & (opa_r[31] ^ dhi[15]);
            end
            default: begin
                pc_nxt = pc_r;
            end
        endcase
    end

    // sequencing: idle, execute, acknowledge
    always_comb begin
        case (state_r)
            BCU_ST_IDLE:
                state_nxt = (av_req.write && av_req.addr == `BCU_REG_CMD)
                          ? BCU_ST_EXEC
                          : ((av_req.read || av_req.write)
                             ? BCU_ST_ACK : BCU_ST_IDLE);
            BCU_ST_EXEC: state_nxt = BCU_ST_ACK;
            BCU_ST_ACK:  state_nxt = BCU_ST_IDLE;
            default:     state_nxt = BCU_ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b)
            state_r <= BCU_ST_IDLE;
        else
            state_r <= state_nxt;
    end

    // waitrequest low only in ACK state
    always_ff @(posedge clk_sys) begin
        if (!rst_b)
            wait_r <= 1'b1;
        else
            wait_r <= (state_nxt != BCU_ST_ACK);
    end

    // register writes and execution results
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            cmd_r     <= 32'h00000000;
            opa_r     <= 32'h00000000;
            opb_r     <= 32'h00000000;
            pc_r      <= `BCU_PC_RST;
            flags_r   <= '0;
            flags_y_r <= '0;
            taken_r   <= 1'b0;
        end else if (state_r == BCU_ST_IDLE && av_req.write) begin
            case (av_req.addr)
                `BCU_REG_CMD: cmd_r <= av_req.writedata;
                `BCU_REG_OPA: opa_r <= av_req.writedata;
                `BCU_REG_OPB: opb_r <= av_req.writedata;
                `BCU_REG_PC:  pc_r  <= av_req.writedata;
                default: ;
            endcase
        end else if (state_r == BCU_ST_EXEC) begin
            pc_r      <= pc_nxt;
            opa_r     <= opa_nxt;
            taken_r   <= taken_nxt;
            flags_r   <= flags_nxt;
            flags_y_r <= flags_y_nxt;
        end
    end

    // read data, valid in ACK state
    always_ff @(posedge clk_sys) begin
        if (!rst_b)
            rdata_r <= 32'h00000000;
        else if (state_r == BCU_ST_IDLE && av_req.read) begin
            case (av_req.addr)
                `BCU_REG_CMD: rdata_r <= {cmd_r[31:16], 3'h0, taken_r,
                                          flags_y_r, flags_r, cmd_r[3:0]};
                `BCU_REG_OPA: rdata_r <= opa_r;
                `BCU_REG_OPB: rdata_r <= opb_r;
                `BCU_REG_PC:  rdata_r <= pc_r;
                default:      rdata_r <= `BCU_UNMAPPED;
            endcase
        end
    end

    assign av_readdata    = rdata_r;
    assign av_waitrequest = wait_r;
    assign flags_out      = flags_r;
    assign pc_out         = pc_r;
    assign count_out      = opa_r;
    assign taken_out      = taken_r;

    // assertions
    sequence s_exec_cdb;
        state_r == BCU_ST_EXEC && op == BCU_OP_CDB;
    endsequence

    a_count_down_dec: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        s_exec_cdb |=> opa_r == $past(opa_r) - 32'h00000001)
        else $error("count-down did not decrement");

    a_count_zero_fall: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        s_exec_cdb ##0 (opa_r == 32'h00000001)
        |=> pc_r == $past(pc_r) + 32'h00000002 && !taken_r)
        else $error("count to zero did not fall through");

    a_flag_set_skip: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        (state_r == BCU_ST_EXEC && op == BCU_OP_CDSET && !flags_r.z)
        |=> $stable(opa_r))
        else $error("flag-set form changed register with Z clear");

    a_flag_clr_run: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        (state_r == BCU_ST_EXEC && op == BCU_OP_CDCLR && !flags_r.z)
        |=> opa_r == $past(opa_r) - 32'h00000001)
        else $error("flag-clear form did not decrement with Z clear");

    a_flag_clr_skip: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        (state_r == BCU_ST_EXEC && op == BCU_OP_CDCLR && flags_r.z)
        |=> $stable(opa_r) && !taken_r)
        else $error("flag-clear form ran with Z set");

    a_jump_indirect: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        (state_r == BCU_ST_EXEC && op == BCU_OP_JIND)
        |=> pc_r == opb_r && taken_r)
        else $error("indirect jump missed source value");

    a_cmp_zero_flag: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        (state_r == BCU_ST_EXEC && op == BCU_OP_CMP)
        |=> flags_r.z == ($past(opa_r) == $past(opb_r)))
        else $error("compare zero flag wrong");

    // answer stands in the cycle right after execute
    a_uncond_taken: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        (state_r == BCU_ST_EXEC && op == BCU_OP_ABS && cc == `BCU_CC_UC)
        |=> pc_r == opb_r && !av_waitrequest)
        else $error("unconditional absolute branch not taken");

    a_carry_clear_br: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        (state_r == BCU_ST_EXEC && op == BCU_OP_ABS
         && cc == `BCU_CC_NC && !fsel.c) |=> taken_r)
        else $error("carry-clear code did not branch");
endmodule : bcu_top

// ### include/bcu_consts.svh
// Purpose: constants for the branch condition unit
// Assumes: 16-bit instruction words, 32-bit program counter
// Notes:   offsets and fields as `define macros
`ifndef BCU_CONSTS_SVH
`define BCU_CONSTS_SVH
// condition codes
`define BCU_CC_UC   4'h0
`define BCU_CC_LO   4'h1
`define BCU_CC_LS   4'h2
`define BCU_CC_HI   4'h3
`define BCU_CC_LT   4'h4
`define BCU_CC_GE   4'h5
`define BCU_CC_LE   4'h6
`define BCU_CC_GT   4'h7
`define BCU_CC_C    4'h8
`define BCU_CC_NC   4'h9
`define BCU_CC_EQ   4'hA
`define BCU_CC_NE   4'hB
`define BCU_CC_V    4'hC
`define BCU_CC_NV   4'hD
`define BCU_CC_N    4'hE
`define BCU_CC_NN   4'hF
// register bus offsets (byte addresses)
`define BCU_REG_CMD    4'h0
`define BCU_REG_OPA    4'h4
`define BCU_REG_OPB    4'h8
`define BCU_REG_PC     4'hC
`define BCU_UNMAPPED   32'hDEADBEEF
// reset value and instruction word width
`define BCU_PC_RST     32'h00000000
`define BCU_WORD_BITS  32'h00000010
`endif

// ### include/bcu_pkg.sv
// Purpose: types for the branch condition unit
// Assumes: none
// Notes:   operation codes written into the command register
package bcu_pkg;
    typedef enum logic [3:0] {
        BCU_OP_NONE    = 4'h0,
        BCU_OP_CDB     = 4'h1,  // count_down_branch, long
        BCU_OP_CDBS    = 4'h2,  // count_down_branch_short
        BCU_OP_CDSET   = 4'h3,  // count_down_when_flag_set
        BCU_OP_CDCLR   = 4'h4,  // count_down_when_flag_clear
        BCU_OP_JIND    = 4'h5,  // register-indirect jump
        BCU_OP_RELS    = 4'h6,  // relative_conditional_branch short
        BCU_OP_RELL    = 4'h7,  // relative_conditional_branch long
        BCU_OP_ABS     = 4'h8,  // absolute_conditional_branch
        BCU_OP_CMP     = 4'h9,  // register/register compare
        BCU_OP_PAIRED_HALF_COMPARE   = 4'hA   // paired_half_compare
    } bcu_op_type;

    typedef struct packed {
        logic n;
        logic c;
        logic z;
        logic v;
    } bcu_flags_type;

    typedef struct packed {
        logic [3:0]  addr;
        logic        read;
        logic        write;
        logic [31:0] writedata;
    } bcu_av_req_type;

    typedef enum logic [2:0] {
        BCU_ST_IDLE = 3'b001,
        BCU_ST_EXEC = 3'b010,
        BCU_ST_ACK  = 3'b100
    } bcu_state_type;
endpackage : bcu_pkg

// ### tb/bcu_top_tb.sv
// Purpose: self-checking bench for the branch condition unit
// Assumes: count-down forms with a 16-bit word two are two words long
// Notes:   flags are set through compares before conditional branches
`timescale 1ns/1ps
`include "bcu_consts.svh"
module bcu_top_tb;
import bcu_pkg::*;
logic           clk_sys;
logic           rst_b;
bcu_av_req_type av_req;
logic [31:0]    av_readdata;
logic           av_waitrequest;
bcu_flags_type  flags_out;
logic [31:0]    pc_out;
logic [31:0]    count_out;
logic           taken_out;
bcu_flags_type  ef;
int             n_errors;
int             comparisons;

bcu_top bcu_top_i (
    .clk_sys        (clk_sys),
    .rst_b          (rst_b),
    .av_req         (av_req),
    .av_readdata    (av_readdata),
    .av_waitrequest (av_waitrequest),
    .flags_out      (flags_out),
    .pc_out         (pc_out),
    .count_out      (count_out),
    .taken_out      (taken_out)
);

initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
end

task automatic chk(input string nm, input logic [31:0] e,
                   input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
        n_errors++;
        $display("ERROR %s expected %h seen %h", nm, e, g);
    end
endtask : chk

// one request, held until waitrequest is seen low at a rising edge
task automatic bus(input logic w, input logic [3:0] a,
                   input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_sys);
    av_req <= '{addr: a, read: !w, write: w, writedata: d};
    do begin
        @(posedge clk_sys);
        n++;
    end while (av_waitrequest !== 1'b0 && n < 40);
    q = av_readdata;
    av_req <= '{addr: 4'h0, read: 1'b0, write: 1'b0, writedata: 32'h0};
    if (n >= 40) begin
        chk("waitrequest", 32'h0, 32'h1);
    end
endtask : bus

task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
endtask : wr

task automatic br(input logic [3:0] op, input logic [3:0] cc,
                  input logic [15:0] w2, input logic [31:0] p0,
                  input logic [31:0] ep, input logic et);
    wr(`BCU_REG_PC, p0);
    wr(`BCU_REG_CMD, {w2, 7'h00, 1'b0, cc, op});
    chk("pc", ep, pc_out);
    chk("taken", {31'h0, et}, {31'h0, taken_out});
endtask : br

// flags from destination minus source
task automatic cmp(input logic [31:0] a, input logic [31:0] b);
    logic [31:0] d;
    d = a - b;
    ef = '{n: d[31], c: a < b, z: d == 32'h0,
           v: (a[31] != b[31]) && (d[31] != a[31])};
    wr(`BCU_REG_OPA, a);
    wr(`BCU_REG_OPB, b);
    wr(`BCU_REG_CMD, {28'h0, BCU_OP_CMP});
    chk("flags", {28'h0, ef}, {28'h0, flags_out});
endtask : cmp

function automatic logic cond(input logic [3:0] cc, input bcu_flags_type f);
    case (cc)
        4'h0: return 1'b1;
        4'h1: return f.c;
        4'h2: return f.c | f.z;
        4'h3: return !f.c && !f.z;
        4'h8: return f.c;
        default: return !f.c;
    endcase
endfunction : cond

task automatic t_reset;
    logic [31:0] q;
    chk("pc", 32'h0, pc_out);
    chk("flags", 32'h0, {28'h0, flags_out});
    chk("count", 32'h0, count_out);
    chk("waitrequest", 32'h1, {31'h0, av_waitrequest});
    bus(1'b0, 4'h2, 32'h0, q);
    chk("unmapped", `BCU_UNMAPPED, q);
    wr(`BCU_REG_OPA, 32'h12345678);
    bus(1'b0, `BCU_REG_OPA, 32'h0, q);
    chk("opa", 32'h12345678, q);
endtask : t_reset

task automatic t_cond;
    logic [31:0] pa [3] = '{32'h5, 32'h3, 32'h80000000};
    logic [31:0] pb [3] = '{32'h5, 32'h7, 32'h1};
    logic [3:0]  cl [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h8, 4'h9};
    logic        t;
    for (int i = 0; i < 3; i++) begin
        cmp(pa[i], pb[i]);
        for (int j = 0; j < 6; j++) begin
            t = cond(cl[j], ef);
            br(BCU_OP_RELS, cl[j], 16'h0005, 32'h100,
               t ? 32'h106 : 32'h101, t);
        end
    end
endtask : t_cond

task automatic t_rel;
    br(BCU_OP_RELS, 4'h0, 16'h0081, 32'h1000, 32'hF82, 1'b1);
    br(BCU_OP_RELS, 4'h0, 16'h007F, 32'h1000, 32'h1080, 1'b1);
    br(BCU_OP_RELL, 4'h0, 16'h8000, 32'h10000, 32'h8002, 1'b1);
    br(BCU_OP_RELL, 4'h0, 16'h7FFF, 32'h10000, 32'h18001, 1'b1);
    cmp(32'h5, 32'h5);
    br(BCU_OP_RELL, 4'h1, 16'h0040, 32'h10000, 32'h10002, 1'b0);
endtask : t_rel

task automatic t_abs_jump;
    cmp(32'h5, 32'h5);
    wr(`BCU_REG_OPB, 32'h89ABCDEF);
    br(BCU_OP_ABS, 4'h0, 16'h0, 32'h40, 32'h89ABCDEF, 1'b1);
    br(BCU_OP_ABS, 4'h1, 16'h0, 32'h40, 32'h43, 1'b0);
    br(BCU_OP_ABS, 4'h9, 16'h0, 32'h40, 32'h89ABCDEF, 1'b1);
    wr(`BCU_REG_OPB, 32'h2468ACE0);
    br(BCU_OP_JIND, 4'h0, 16'h0, 32'h7, 32'h2468ACE0, 1'b1);
endtask : t_abs_jump

// low half equal, high half lower: X and Y flags differ
task automatic t_pair;
    logic [31:0] q;
    wr(`BCU_REG_OPA, 32'h00030005);
    wr(`BCU_REG_OPB, 32'h00070005);
    wr(`BCU_REG_CMD, {28'h0, BCU_OP_PAIRED_HALF_COMPARE});
    chk("flags", 32'h2, {28'h0, flags_out});
    bus(1'b0, `BCU_REG_CMD, 32'h0, q);
    chk("cmd", 32'h00000C2A, q);
    wr(`BCU_REG_PC, 32'h100);
    wr(`BCU_REG_CMD, {16'h0005, 7'h00, 1'b1, 4'h1, BCU_OP_RELS});
    chk("pc", 32'h106, pc_out);
    br(BCU_OP_RELS, 4'h1, 16'h0005, 32'h100, 32'h101, 1'b0);
endtask : t_pair

task automatic t_count;
    wr(`BCU_REG_OPA, 32'h3);
    br(BCU_OP_CDB, 4'h0, 16'h7FFF, 32'h1000, 32'h9001, 1'b1);
    chk("count", 32'h2, count_out);
    br(BCU_OP_CDB, 4'h0, 16'h8000, 32'h10000, 32'h8002, 1'b1);
    br(BCU_OP_CDB, 4'h0, 16'h8000, 32'h10000, 32'h10002, 1'b0);
    chk("count", 32'h0, count_out);
    wr(`BCU_REG_OPA, 32'h5);
    br(BCU_OP_CDBS, 4'h0, 16'h0060, 32'h1F4, 32'h1D5, 1'b1);
    br(BCU_OP_CDBS, 4'h0, 16'h0020, 32'h1F4, 32'h215, 1'b1);
    chk("count", 32'h3, count_out);
endtask : t_count

task automatic t_count_flag;
    cmp(32'h4, 32'h4);
    wr(`BCU_REG_OPA, 32'h3);
    br(BCU_OP_CDSET, 4'h0, 16'h0010, 32'h200, 32'h212, 1'b1);
    chk("count", 32'h2, count_out);
    br(BCU_OP_CDCLR, 4'h0, 16'h0010, 32'h200, 32'h202, 1'b0);
    chk("count", 32'h2, count_out);
    cmp(32'h4, 32'h5);
    wr(`BCU_REG_OPA, 32'h1);
    br(BCU_OP_CDSET, 4'h0, 16'h0010, 32'h200, 32'h202, 1'b0);
    chk("count", 32'h1, count_out);
    br(BCU_OP_CDCLR, 4'h0, 16'h0010, 32'h200, 32'h202, 1'b0);
    chk("count", 32'h0, count_out);
    wr(`BCU_REG_OPA, 32'h2);
    br(BCU_OP_CDCLR, 4'h0, 16'h0010, 32'h200, 32'h212, 1'b1);
    chk("count", 32'h1, count_out);
endtask : t_count_flag

task automatic close_out;
    if (n_errors == 0 && comparisons > 0) begin
        $display("[ PASS ]");
    end else begin
        $display("[ FAIL ]");
    end
    $finish;
endtask : close_out

initial begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    close_out();
end

initial begin
    n_errors = 0;
    comparisons = 0;
    rst_b = 1'b0;
    av_req = '{addr: 4'h0, read: 1'b0, write: 1'b0, writedata: 32'h0};
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    t_reset();
    t_cond();
    t_rel();
    t_abs_jump();
    t_pair();
    t_count();
    t_count_flag();
    close_out();
end
endmodule : bcu_top_tb
